// *** common/cbt_regs.svh ***
`ifndef CBT_REGS_SVH
`define CBT_REGS_SVH

// Program counter lead over the executing halfword (prefetch)
`define CBT_PC_AHEAD 32'h0000_0004
// Software trap vector
`define CBT_TRAP_VECTOR 32'h0000_0008
// Supervisor mode encoding of the mode field
`define CBT_MODE_SUPERVISOR 5'h13
// Status word field positions
`define CBT_SW_N 31
`define CBT_SW_Z 30
`define CBT_SW_C 29
`define CBT_SW_V 28
`define CBT_SW_T 5
// Top opcode patterns of the decoded formats
`define CBT_OP_COND 4'hd
`define CBT_OP_UNCOND 5'h1c
`define CBT_OP_LONG 4'hf
`define CBT_COND_UNDEF 4'he
`define CBT_COND_TRAP 4'hf
// Cycles per class: one-word branch refill matches the 32-bit set
`define CBT_CYC_SEQ 2'h1
`define CBT_CYC_BRANCH 2'h3
`define CBT_CYC_LONG1 2'h1
`define CBT_CYC_LONG2 2'h3

`endif

// *** common/cbt_pkg.sv ***
package cbt_pkg;

  typedef enum logic [5:0] {
    CBT_NONE   = 6'h01,
    CBT_CBR    = 6'h02,
    CBT_TRAP   = 6'h04,
    CBT_UBR    = 6'h08,
    CBT_LONG1  = 6'h10,
    CBT_LONG2  = 6'h20
  } cbt_class_e;

  typedef enum logic [2:0] {
    CBT_ST_IDLE = 3'h1,
    CBT_ST_BUSY = 3'h2,
    CBT_ST_DONE = 3'h4
  } cbt_state_e;

endpackage

// *** rtl/cbt_cond_eval.sv ***
`timescale 1ns/100ps
`include "cbt_regs.svh"

// Condition evaluation over the four flags, registered output
module cbt_cond_eval
  import cbt_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Condition and flags
  input wire logic [3:0] i_cond,
  input wire logic i_n,
  input wire logic i_z,
  input wire logic i_c,
  input wire logic i_v,
  // Result
  output logic o_pass
);

  typedef struct packed {
    logic pass;
  } cbt_ce_s;

  cbt_ce_s st_q;
  cbt_ce_s st_d;

  // Flag test per condition code
  function automatic logic cond_ok(input logic [3:0] c, input logic n, input logic z,
                                   input logic cy, input logic v);
    case (c)
      4'h0: cond_ok = z;
      4'h1: cond_ok = !z;
      4'h2: cond_ok = cy;
      4'h3: cond_ok = !cy;
      4'h4: cond_ok = n;
      4'h5: cond_ok = !n;
      4'h6: cond_ok = v;
      4'h7: cond_ok = !v;
      4'h8: cond_ok = cy && !z;
      4'h9: cond_ok = !cy || z;
      4'ha: cond_ok = (n == v);
      4'hb: cond_ok = (n != v);
      4'hc: cond_ok = !z && (n == v);
      4'hd: cond_ok = z || (n != v);
      default: cond_ok = 1'b0;           // Undefined and trap codes never branch
    endcase
  endfunction

  // Next state
  always_comb begin
    st_d = st_q;
    st_d.pass = cond_ok(i_cond, i_n, i_z, i_c, i_v);
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_pass = st_q.pass;

endmodule

// *** rtl/cbt_decoder.sv ***
`timescale 1ns/100ps
`include "cbt_regs.svh"

// How it works
// - Targets use instruction address plus four
// - Code 0000 on Z set, 0001 clear
// - Code 0010 on C set, 0011 clear
// - Code 0100 on N set, 0101 clear
// - Code 0110 on V set, 0111 clear
// - 1000 C and not Z; 1001 opposite
// - 1010 N equals V; 1011 differs
// - 1100 not Z and N=V; 1101 opposite
// - Conditional offset shifted left once, halfword aligned
// - Condition 1111 decodes as software trap
// - Trap saves link and status, vectors supervisor
// - Trap comment field ignored by hardware
// - Cycle counts match 32-bit set equivalents
// - Unconditional offset shifted once, added to counter
// - First half: counter plus offset<<12 into link
// - Second half: link plus offset<<1, link=next|1
// - Long call pair is native behaviour
module cbt_decoder
  import cbt_pkg::*;
#(
  parameter int unsigned ADDR_W = 32
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Instruction issue
  input wire logic i_issue,
  input wire logic [15:0] i_instr,
  input wire logic [ADDR_W-1:0] i_instr_addr,
  // Architectural state in
  input wire logic [31:0] i_current_status_word,
  input wire logic [ADDR_W-1:0] i_link_register,
  // Program counter update
  output logic o_pc_we,
  output logic [ADDR_W-1:0] o_program_counter,
  // Link register update
  output logic o_lr_we,
  output logic [ADDR_W-1:0] o_link_register,
  // Status update for a trap
  output logic o_trap,
  output logic [31:0] o_saved_status_word,
  output logic [31:0] o_current_status_word,
  // Pipeline handshake
  output logic o_busy,
  output logic o_done,
  output logic o_undefined
);

  // Check width at elaboration
  if (ADDR_W != 32) begin : g_bad_width
    $error("cbt_decoder supports a 32-bit address only");
  end

  typedef struct packed {
    cbt_state_e state;
    cbt_class_e cls;
    logic [1:0] cnt;
    logic [15:0] instr;
    logic [ADDR_W-1:0] addr;
    logic [31:0] sw;
    logic [ADDR_W-1:0] lr;
    logic pc_we;
    logic [ADDR_W-1:0] pc;
    logic lr_we;
    logic [ADDR_W-1:0] lr_out;
    logic trap;
    logic [31:0] saved_status_word;
    logic [31:0] current_status_word;
    logic done;
    logic undef;
    logic pass;
    logic busy;
  } cbt_dec_s;

  cbt_dec_s st_q;
  cbt_dec_s st_d;
  logic cond_pass;

  // --------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------

  // Classify a halfword into one of the branch formats
  function automatic cbt_class_e classify(input logic [15:0] ins);
    if (ins[15:12] == `CBT_OP_COND) begin
      if (ins[11:8] == `CBT_COND_TRAP) begin
        classify = CBT_TRAP;
      end else begin
        classify = CBT_CBR;
      end
    end else if (ins[15:11] == `CBT_OP_UNCOND) begin
      classify = CBT_UBR;
    end else if (ins[15:12] == `CBT_OP_LONG) begin
      classify = ins[11] ? CBT_LONG2 : CBT_LONG1;
    end else begin
      classify = CBT_NONE;
    end
  endfunction

  // Cycles a class occupies, matching the 32-bit set
  function automatic logic [1:0] class_cycles(input cbt_class_e c, input logic taken);
    case (c)
      CBT_CBR: class_cycles = taken ? `CBT_CYC_BRANCH : `CBT_CYC_SEQ;
      CBT_TRAP: class_cycles = `CBT_CYC_BRANCH;
      CBT_UBR: class_cycles = `CBT_CYC_BRANCH;
      CBT_LONG1: class_cycles = `CBT_CYC_LONG1;
      CBT_LONG2: class_cycles = `CBT_CYC_LONG2;
      default: class_cycles = `CBT_CYC_SEQ;
    endcase
  endfunction

  // --------------------------------------------------------------
  // Condition evaluator, one cycle after issue
  // --------------------------------------------------------------

  cbt_cond_eval u_cond (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_cond(i_instr[11:8]),
    .i_n(i_current_status_word[`CBT_SW_N]),
    .i_z(i_current_status_word[`CBT_SW_Z]),
    .i_c(i_current_status_word[`CBT_SW_C]),
    .i_v(i_current_status_word[`CBT_SW_V]),
    .o_pass(cond_pass)
  );

  // --------------------------------------------------------------
  // Execution datapath and sequencing
  // --------------------------------------------------------------

  // One instruction at a time; results appear on the last busy cycle
  always_comb begin
    logic [ADDR_W-1:0] pc_now;
    logic [ADDR_W-1:0] off9;
    logic [ADDR_W-1:0] off12;
    logic [ADDR_W-1:0] off_hi;
    logic [ADDR_W-1:0] off_lo;
    logic [31:0] new_sw;
    logic taken;
    // The evaluator follows the live inputs, so its verdict is held after the first busy cycle
    taken = (st_q.cnt == 2'h0) ? cond_pass : st_q.pass;
    pc_now = st_q.addr + `CBT_PC_AHEAD;
    off9 = {{(ADDR_W-9){st_q.instr[7]}}, st_q.instr[7:0], 1'b0};
    off12 = {{(ADDR_W-12){st_q.instr[10]}}, st_q.instr[10:0], 1'b0};
    off_hi = {{(ADDR_W-23){st_q.instr[10]}}, st_q.instr[10:0], 12'h000};
    off_lo = {{(ADDR_W-12){1'b0}}, st_q.instr[10:0], 1'b0};
    new_sw = st_q.sw;
    new_sw[`CBT_SW_T] = 1'b0;
    new_sw[4:0] = `CBT_MODE_SUPERVISOR;
    st_d = st_q;
    st_d.pc_we = 1'b0;
    st_d.lr_we = 1'b0;
    st_d.trap = 1'b0;
    st_d.done = 1'b0;
    st_d.undef = 1'b0;
    case (st_q.state)
      CBT_ST_IDLE: begin
        if (i_issue) begin
          st_d.instr = i_instr;
          st_d.addr = i_instr_addr;
          st_d.sw = i_current_status_word;
          st_d.lr = i_link_register;
          st_d.cls = classify(i_instr);
          st_d.state = CBT_ST_BUSY;
          st_d.cnt = 2'h0;
        end
      end
      CBT_ST_BUSY: begin
        // Cycle count known once the condition is resolved
        st_d.pass = taken;
        if (st_q.cnt == 2'h0 && class_cycles(st_q.cls, taken) == 2'h1 ||
            st_q.cnt == class_cycles(st_q.cls, taken) - 2'h1) begin
          st_d.state = CBT_ST_DONE;
          st_d.done = 1'b1;
          case (st_q.cls)
            CBT_CBR: begin
              if (st_q.instr[11:8] == `CBT_COND_UNDEF) begin
                st_d.undef = 1'b1;
              end else if (taken) begin
                st_d.pc_we = 1'b1;
                st_d.pc = pc_now + off9;
              end
            end
            CBT_TRAP: begin
              // Comment field bits [7:0] take no part here
              st_d.pc_we = 1'b1;
              st_d.pc = `CBT_TRAP_VECTOR;
              st_d.lr_we = 1'b1;
              st_d.lr_out = st_q.addr + 32'h0000_0002;
              st_d.trap = 1'b1;
              st_d.saved_status_word = st_q.sw;
              st_d.current_status_word = new_sw;
            end
            CBT_UBR: begin
              st_d.pc_we = 1'b1;
              st_d.pc = pc_now + off12;
            end
            CBT_LONG1: begin
              st_d.lr_we = 1'b1;
              st_d.lr_out = pc_now + off_hi;
            end
            CBT_LONG2: begin
              st_d.pc_we = 1'b1;
              st_d.pc = st_q.lr + off_lo;
              st_d.lr_we = 1'b1;
              st_d.lr_out = (st_q.addr + 32'h0000_0002) | 32'h0000_0001;
            end
            default: begin
              st_d.undef = 1'b0;
            end
          endcase
        end else begin
          st_d.cnt = st_q.cnt + 2'h1;
        end
      end
      CBT_ST_DONE: begin
        st_d.state = CBT_ST_IDLE;
      end
      default: begin
        st_d.state = CBT_ST_IDLE;
      end
    endcase
    // Busy is registered so the output comes straight from a flip-flop
    st_d.busy = (st_d.state != CBT_ST_IDLE);
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= '{state: CBT_ST_IDLE, cls: CBT_NONE, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign o_pc_we = st_q.pc_we;
  assign o_program_counter = st_q.pc;
  assign o_lr_we = st_q.lr_we;
  assign o_link_register = st_q.lr_out;
  assign o_trap = st_q.trap;
  assign o_saved_status_word = st_q.saved_status_word;
  assign o_current_status_word = st_q.current_status_word;
  assign o_busy = st_q.busy;
  assign o_done = st_q.done;
  assign o_undefined = st_q.undef;

endmodule

// *** verification/cbt_decoder_checker.sv ***
`timescale 1ns/100ps
`include "cbt_regs.svh"
// ----------------------------------------
// Port checker for the branch/trap decoder
// ----------------------------------------
module cbt_decoder_checker
  import cbt_pkg::*;
#(
  parameter int unsigned ADDR_W = 32
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Issue side
  input wire logic i_issue,
  input wire logic [15:0] i_instr,
  input wire logic [ADDR_W-1:0] i_instr_addr,
  input wire logic [31:0] i_current_status_word,
  input wire logic [ADDR_W-1:0] i_link_register,
  // Results
  input wire logic o_pc_we,
  input wire logic [ADDR_W-1:0] o_program_counter,
  input wire logic o_lr_we,
  input wire logic [ADDR_W-1:0] o_link_register,
  input wire logic o_trap,
  input wire logic [31:0] o_saved_status_word,
  input wire logic [31:0] o_current_status_word,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_undefined
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // Accepted issue and the branch target it implies, kept for the done cycle
  logic take;
  logic is_ub;
  logic [31:0] ub_tgt;
  assign take = i_issue && !o_busy;
  assign is_ub = take && (i_instr[15:11] == `CBT_OP_UNCOND);
  assign ub_tgt = i_instr_addr + 32'h4 + {{20{i_instr[10]}}, i_instr[10:0], 1'b0};

  a_issue_busy: assert property (take |=> o_busy) else $error("busy not raised");
  a_done_latency: assert property (take |=> !o_done ##1 (o_done or (!o_done ##1 !o_done ##1 o_done)))
    else $error("done latency wrong");
  a_busy_release: assert property (o_done |=> !o_busy && !o_done) else $error("no release");
  a_writes_at_done: assert property ((o_pc_we || o_lr_we || o_trap || o_undefined) |-> o_done)
    else $error("write outside done");
  a_trap_vector: assert property (o_trap |-> o_pc_we && o_program_counter == `CBT_TRAP_VECTOR)
    else $error("trap vector wrong");
  a_trap_mode: assert property (o_trap |-> o_lr_we && !o_current_status_word[`CBT_SW_T] &&
    o_current_status_word[4:0] == `CBT_MODE_SUPERVISOR) else $error("trap mode wrong");
  a_trap_saved: assert property (o_trap |-> o_saved_status_word == $past(i_current_status_word, 4))
    else $error("saved status wrong");
  a_trap_link: assert property (o_trap |-> o_link_register == $past(i_instr_addr, 4) + 32'h2)
    else $error("trap link wrong");
  a_undef_quiet: assert property (o_undefined |-> !o_pc_we && !o_lr_we && !o_trap)
    else $error("undefined wrote state");
  a_uncond_target: assert property ($past(is_ub, 4) && o_done |->
    o_pc_we && o_program_counter == $past(ub_tgt, 4)) else $error("branch target wrong");
  // Main scenarios reached
  c_trap: cover property (o_trap);
  c_undef: cover property (o_undefined);
  c_long_first: cover property (o_lr_we && !o_pc_we);
endmodule

// *** verification/compact_branch_trap_decoder_tb.sv ***
`timescale 1ns/100ps
`include "cbt_regs.svh"
// ----------------------------------------
// Self-checking bench with a reference model
// ----------------------------------------
module compact_branch_trap_decoder_tb
  import cbt_pkg::*;
;
  logic clk = 0, rst_n = 0, iss = 0;
  logic [15:0] ins = 0;
  logic [31:0] adr = 0, sw = 0, lr = 0, m_lr = 0;
  logic pw, lw, tr, bz, dn, un;
  logic [31:0] pc, lo, ss, cs;
  int fails = 0, n_checks = 0;

  cbt_decoder uut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_issue(iss), .i_instr(ins),
    .i_instr_addr(adr), .i_current_status_word(sw), .i_link_register(lr), .o_pc_we(pw),
    .o_program_counter(pc), .o_lr_we(lw), .o_link_register(lo), .o_trap(tr),
    .o_saved_status_word(ss), .o_current_status_word(cs), .o_busy(bz), .o_done(dn),
    .o_undefined(un));

  // Clock, 4 ns period
  initial begin
    forever #2 clk = ~clk;
  end

  // Condition table; odd codes are the inverse of the even code below them
  function automatic bit cond_ok(logic [3:0] c, logic [3:0] f);
    bit n = f[3], z = f[2], cy = f[1], v = f[0], b;
    case (c[3:1])
      3'd0: b = z;
      3'd1: b = cy;
      3'd2: b = n;
      3'd3: b = v;
      3'd4: b = cy && !z;
      3'd5: b = (n == v);
      default: b = !z && (n == v);
    endcase
    return b ^ c[0];
  endfunction

  function automatic logic [31:0] ra();
    return $urandom & 32'hffff_fffe;
  endfunction

  task automatic chk(bit ok, string m);
    n_checks++;
    if (!ok) begin
      $display("[FAIL] %0t %s", $time, m);
      fails++;
    end
  endtask

  // Issue one halfword, wait for done and compare with the model
  task automatic exec(logic [15:0] i, logic [31:0] a, logic [31:0] s);
    int k = 0, cy = 1;
    bit epw = 0, elw = 0, etr = 0, eun = 0;
    logic [31:0] epc = 0, elr = 0;
    if (i[15:12] == `CBT_OP_COND && i[11:8] == `CBT_COND_UNDEF) eun = 1;
    else if (i[15:12] == `CBT_OP_COND && i[11:8] == `CBT_COND_TRAP) begin
      etr = 1; epw = 1; elw = 1; cy = 3; epc = `CBT_TRAP_VECTOR; elr = a + 32'h2;
    end else if (i[15:12] == `CBT_OP_COND) begin
      epw = cond_ok(i[11:8], s[31:28]);
      cy = epw ? 3 : 1;
      epc = a + 32'h4 + {{23{i[7]}}, i[7:0], 1'b0};
    end else if (i[15:11] == `CBT_OP_UNCOND) begin
      epw = 1; cy = 3; epc = a + 32'h4 + {{20{i[10]}}, i[10:0], 1'b0};
    end else if (i[15:12] == `CBT_OP_LONG && !i[11]) begin
      elw = 1; elr = a + 32'h4 + {{9{i[10]}}, i[10:0], 12'h0};
    end else if (i[15:12] == `CBT_OP_LONG) begin
      epw = 1; elw = 1; cy = 3; epc = m_lr + {20'h0, i[10:0], 1'b0}; elr = (a + 32'h2) | 32'h1;
    end
    @(posedge clk);
    #1;
    iss = 1; ins = i; adr = a; sw = s; lr = m_lr;
    @(posedge clk);
    #1;
    iss = 0; ins = 16'($urandom);
    while (dn !== 1'b1 && k < 8) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(k == cy, "latency");
    chk(pw === epw && (!epw || pc === epc), "program counter");
    chk(lw === elw && (!elw || lo === elr), "link register");
    chk(tr === etr && un === eun, "trap or undefined flag");
    if (etr) chk(ss === s && cs === {s[31:6], 1'b0, `CBT_MODE_SUPERVISOR}, "status");
    if (elw) m_lr = elr;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog, far beyond the expected run
  initial begin
    #100000;
    fails++;
    summarize();
  end

  // Main sequence: every condition code, branches, long pairs, others
  initial begin
    logic [31:0] a;
    void'($urandom(32'h726eb6d4));
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1;
    for (int c = 0; c < 16; c++) begin
      repeat (6) exec({4'hd, c[3:0], 8'($urandom)}, ra(), $urandom);
    end
    exec(16'he7fe, 32'h100, $urandom);
    repeat (12) exec({5'h1c, 11'($urandom)}, ra(), $urandom);
    repeat (8) begin
      a = ra();
      exec({5'h1e, 11'($urandom)}, a, $urandom);
      exec({5'h1f, 11'($urandom)}, a + 32'h2, $urandom);
    end
    repeat (6) exec({3'h0, 13'($urandom)}, ra(), $urandom);
    summarize();
  end
endmodule

bind cbt_decoder cbt_decoder_checker #(.ADDR_W(ADDR_W)) u_chk (.i_ref_clk(i_ref_clk),
  .i_arst_n(i_arst_n), .i_issue(i_issue), .i_instr(i_instr), .i_instr_addr(i_instr_addr),
  .i_current_status_word(i_current_status_word), .i_link_register(i_link_register),
  .o_pc_we(o_pc_we), .o_program_counter(o_program_counter), .o_lr_we(o_lr_we),
  .o_link_register(o_link_register), .o_trap(o_trap), .o_saved_status_word(o_saved_status_word),
  .o_current_status_word(o_current_status_word), .o_busy(o_busy), .o_done(o_done),
  .o_undefined(o_undefined));
